// ==== common/bsdp_pkg.sv ====
// shared constants for the bank-switched dual-port sram port logic
package bsdp_pkg;
  // ****************************************************************
  // array organisation
  // ****************************************************************
  localparam int BSDP_NPORT = 2;
  localparam int BSDP_BANK_W = 6;
  localparam int BSDP_NBANK = 64;
  localparam int BSDP_OFFS_W = 12;
  localparam int BSDP_BANK_DEPTH = 4096;
  localparam int BSDP_ADDR_W = BSDP_BANK_W + BSDP_OFFS_W;
  localparam int BSDP_DATA_W = 18;
  localparam int BSDP_NLANE = 2;
  localparam int BSDP_LANE_W = 9;
  // lane indices inside the word
  localparam int BSDP_LANE_LOWER = 0;
  localparam int BSDP_LANE_UPPER = 1;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [BSDP_ADDR_W-1:0] BSDP_ADDR_RST = 18'h00000;
  localparam logic [BSDP_DATA_W-1:0] BSDP_DATA_RST = 18'h00000;
  localparam logic [BSDP_NLANE-1:0] BSDP_DRIVE_RST = 2'h0;
endpackage

// ==== rtl/bsdp_dp_mem.sv ====
// two-port word array with per-lane write enables and registered read data
`timescale 1ns/10ps
`default_nettype none
module bsdp_dp_mem
  import bsdp_pkg::*;
#(
  parameter int ADDR_W = BSDP_ADDR_W,
  parameter int LANE_W = BSDP_LANE_W,
  parameter int NLANE = BSDP_NLANE
)
(
  input wire logic i_ref_clk,
  input wire logic [ADDR_W-1:0] i_addr_a,
  input wire logic [NLANE-1:0] i_we_a,
  input wire logic [NLANE*LANE_W-1:0] i_wdata_a,
  output logic [NLANE*LANE_W-1:0] o_rdata_a,
  input wire logic [ADDR_W-1:0] i_addr_b,
  input wire logic [NLANE-1:0] i_we_b,
  input wire logic [NLANE*LANE_W-1:0] i_wdata_b,
  output logic [NLANE*LANE_W-1:0] o_rdata_b
);
  // ****************************************************************
  // one array per lane so a lane writes alone
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NLANE; g = g + 1)
    begin : g_lane
      logic [LANE_W-1:0] cells [0:(2**ADDR_W)-1];
      // port b written last: a same-word clash leaves b's data, which is undefined anyway
      always_ff @(posedge i_ref_clk)
      begin
        if (i_we_a[g])
        begin
          cells[i_addr_a] <= i_wdata_a[g*LANE_W +: LANE_W];
        end
        if (i_we_b[g])
        begin
          cells[i_addr_b] <= i_wdata_b[g*LANE_W +: LANE_W];
        end
        o_rdata_a[g*LANE_W +: LANE_W] <= cells[i_addr_a];
        // a word written by one port is seen by the other from the next edge on
        o_rdata_b[g*LANE_W +: LANE_W] <= cells[i_addr_b];
      end
    end
  endgenerate
endmodule // bsdp_dp_mem
`default_nettype wire

// ==== rtl/bsdp_addr_ctr.sv ====
// per-port address counter with load, advance and repeat
`timescale 1ns/10ps
`default_nettype none
module bsdp_addr_ctr
  import bsdp_pkg::*;
#(
  parameter int ADDR_W = BSDP_ADDR_W
)
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [ADDR_W-1:0] i_ext_addr,
  input wire logic i_address_load_strobe_n,
  input wire logic i_counter_advance_enable_n,
  input wire logic i_repeat_n,
  output logic [ADDR_W-1:0] o_access_addr
);
  logic [ADDR_W-1:0] count;
  logic [ADDR_W-1:0] load_value;
  logic [ADDR_W-1:0] next_count;
  logic [ADDR_W-1:0] next_load_value;

  // ****************************************************************
  // next address
  // ****************************************************************
  always_comb
  begin
    next_load_value = load_value;
    if (!i_address_load_strobe_n)
    begin
      next_count = i_ext_addr;
      next_load_value = i_ext_addr;
    end
    else if (!i_repeat_n)
    begin
      next_count = load_value;
    end
    else if (!i_counter_advance_enable_n)
    begin
      // bank and offset roll over together as one field
      next_count = ADDR_W'(count + 1'b1);
    end
    else
    begin
      next_count = count;
    end
    o_access_addr = next_count;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      count <= BSDP_ADDR_RST;
      load_value <= BSDP_ADDR_RST;
    end
    else
    begin
      count <= next_count;
      load_value <= next_load_value;
    end
  end
endmodule // bsdp_addr_ctr
`default_nettype wire

// ==== rtl/bsdp_top.sv ====
// two-port access logic around a bank-switched shared word array
`timescale 1ns/10ps
`default_nettype none
module bsdp_top
  import bsdp_pkg::*;
#(
  parameter int NPORT = BSDP_NPORT,
  parameter int BANK_W = BSDP_BANK_W,
  parameter int OFFS_W = BSDP_OFFS_W,
  parameter int NLANE = BSDP_NLANE,
  parameter int LANE_W = BSDP_LANE_W
)
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [NPORT-1:0] i_pipeline_select,
  input wire logic [NPORT-1:0] i_address_load_strobe_n,
  input wire logic [NPORT-1:0] i_counter_advance_enable_n,
  input wire logic [NPORT-1:0] i_repeat_n,
  input wire logic [NPORT-1:0] i_chip_select_low_active_n,
  input wire logic [NPORT-1:0] i_chip_select_high_active,
  input wire logic [NPORT-1:0] i_upper_byte_enable_n,
  input wire logic [NPORT-1:0] i_lower_byte_enable_n,
  input wire logic [NPORT-1:0] i_write_n,
  input wire logic [NPORT-1:0] i_output_enable_n,
  input wire logic [NPORT*BANK_W-1:0] i_bank_select,
  input wire logic [NPORT*OFFS_W-1:0] i_address,
  input wire logic [NPORT*NLANE*LANE_W-1:0] i_data,
  output logic [NPORT*NLANE*LANE_W-1:0] o_data,
  output logic [NPORT*NLANE-1:0] o_data_oe_n,
  output logic o_bank_collision
);
  localparam int ADDR_W = BANK_W + OFFS_W;
  localparam int DATA_W = NLANE * LANE_W;

  // ****************************************************************
  // decoding shared by both ports
  // ****************************************************************
  function automatic logic bsdp_selected(input logic cs_low_n, input logic cs_high);
    bsdp_selected = !cs_low_n && cs_high;
  endfunction

  logic [ADDR_W-1:0] access_addr [NPORT];
  logic [NLANE-1:0] lane_we [NPORT];
  logic [DATA_W-1:0] mem_rdata [NPORT];
  logic [NPORT-1:0] port_sel;

  // ****************************************************************
  // per-port control and output path
  // ****************************************************************
  genvar p;
  generate
    for (p = 0; p < NPORT; p = p + 1)
    begin : g_port
      logic [NLANE-1:0] lane_en;
      logic [NLANE-1:0] rd_drive1;
      logic [NLANE-1:0] rd_drive2;
      logic [NLANE-1:0] out_drive;
      logic [DATA_W-1:0] rdata2;
      logic [DATA_W-1:0] out_data;
      logic [NLANE-1:0] next_rd_drive1;
      logic [NLANE-1:0] next_rd_drive2;
      logic [NLANE-1:0] next_out_drive;
      logic [DATA_W-1:0] next_rdata2;
      logic [DATA_W-1:0] next_out_data;

      // bank select is the upper part of the counter field
      bsdp_addr_ctr #(
        .ADDR_W(ADDR_W)
      ) u_ctr (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_ext_addr({i_bank_select[p*BANK_W +: BANK_W], i_address[p*OFFS_W +: OFFS_W]}),
        .i_address_load_strobe_n(i_address_load_strobe_n[p]),
        .i_counter_advance_enable_n(i_counter_advance_enable_n[p]),
        .i_repeat_n(i_repeat_n[p]),
        .o_access_addr(access_addr[p])
      );

      always_comb
      begin
        port_sel[p] = bsdp_selected(i_chip_select_low_active_n[p], i_chip_select_high_active[p]);
        lane_en = '0;
        lane_en[BSDP_LANE_UPPER] = !i_upper_byte_enable_n[p];
        lane_en[BSDP_LANE_LOWER] = !i_lower_byte_enable_n[p];
        // a deselected port neither writes nor drives read data; the array still reads its word
        lane_we[p] = (port_sel[p] && !i_write_n[p]) ? lane_en : '0;
        // drive flags travel with the read data they belong to
        next_rd_drive1 = (port_sel[p] && i_write_n[p]) ? lane_en : '0;
        next_rd_drive2 = rd_drive1;
        next_rdata2 = mem_rdata[p];
        // pipelined mode adds one register stage after the array
        if (i_pipeline_select[p])
        begin
          next_out_data = rdata2;
          next_out_drive = rd_drive2;
        end
        else
        begin
          next_out_data = mem_rdata[p];
          next_out_drive = rd_drive1;
        end
      end

      always_ff @(posedge i_ref_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          rd_drive1 <= BSDP_DRIVE_RST;
          rd_drive2 <= BSDP_DRIVE_RST;
          out_drive <= BSDP_DRIVE_RST;
          rdata2 <= BSDP_DATA_RST;
          out_data <= BSDP_DATA_RST;
        end
        else
        begin
          rd_drive1 <= next_rd_drive1;
          rd_drive2 <= next_rd_drive2;
          out_drive <= next_out_drive;
          rdata2 <= next_rdata2;
          out_data <= next_out_data;
        end
      end

      // output enable bypasses the clock so it can float the bus at once
      assign o_data_oe_n[p*NLANE +: NLANE] = ~out_drive | {NLANE{i_output_enable_n[p]}};
      assign o_data[p*DATA_W +: DATA_W] = out_data;
    end
  endgenerate

  // ****************************************************************
  // shared array
  // ****************************************************************
  // both ports reach the array in the same cycle; distinct banks never interfere
  bsdp_dp_mem #(
    .ADDR_W(ADDR_W),
    .LANE_W(LANE_W),
    .NLANE(NLANE)
  ) u_mem (
    .i_ref_clk(i_ref_clk),
    .i_addr_a(access_addr[0]),
    .i_we_a(lane_we[0]),
    .i_wdata_a(i_data[0 +: DATA_W]),
    .o_rdata_a(mem_rdata[0]),
    .i_addr_b(access_addr[1]),
    .i_we_b(lane_we[1]),
    .i_wdata_b(i_data[DATA_W +: DATA_W]),
    .o_rdata_b(mem_rdata[1])
  );

  // ****************************************************************
  // same-bank clash flag
  // ****************************************************************
  logic next_bank_collision;

  always_comb
  begin
    // both accesses are invalid then; the flag lets the controller see it
    next_bank_collision = port_sel[0] && port_sel[1]
      && (access_addr[0][ADDR_W-1 -: BANK_W] == access_addr[1][ADDR_W-1 -: BANK_W]);
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_bank_collision <= 1'b0;
    end
    else
    begin
      o_bank_collision <= next_bank_collision;
    end
  end
endmodule // bsdp_top
`default_nettype wire

// ==== verification/bsdp_chk_sva.sv ====
// concurrent checks on the pins of the two-port access logic
`timescale 1ns/10ps
`default_nettype none
module bsdp_chk
  import bsdp_pkg::*;
#(
  parameter int NPORT = BSDP_NPORT,
  parameter int BANK_W = BSDP_BANK_W,
  parameter int NLANE = BSDP_NLANE
)
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [NPORT-1:0] i_pipeline_select,
  input wire logic [NPORT-1:0] i_address_load_strobe_n,
  input wire logic [NPORT-1:0] i_chip_select_low_active_n,
  input wire logic [NPORT-1:0] i_chip_select_high_active,
  input wire logic [NPORT-1:0] i_upper_byte_enable_n,
  input wire logic [NPORT-1:0] i_lower_byte_enable_n,
  input wire logic [NPORT-1:0] i_write_n,
  input wire logic [NPORT-1:0] i_output_enable_n,
  input wire logic [NPORT*BANK_W-1:0] i_bank_select,
  input wire logic [NPORT*NLANE-1:0] o_data_oe_n,
  input wire logic o_bank_collision
);
  wire logic s0 = !i_chip_select_low_active_n[0] && i_chip_select_high_active[0];
  wire logic s1 = !i_chip_select_low_active_n[1] && i_chip_select_high_active[1];
  wire logic both = s0 && s1;
  wire logic rd0 = s0 && i_write_n[0];
  wire logic ft0 = !i_pipeline_select[0];
  wire logic ld2 = i_address_load_strobe_n == 2'h0;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // ****************************************
  // port pins
  // ****************************************
  oe_pin_float_a: assert property (i_output_enable_n[0] |-> o_data_oe_n[1:0] == 2'h3)
    else $error("oe pin ignored");
  desel_float_a: assert property (ft0 && !s0 |-> ##2 o_data_oe_n[1:0] == 2'h3)
    else $error("deselect slot driven");
  lane_float_a: assert property (ft0 && rd0 && i_upper_byte_enable_n[0] |-> ##2 o_data_oe_n[1])
    else $error("disabled lane driven");
  flow_drive_a: assert property (ft0 && rd0 && !i_lower_byte_enable_n[0] ##2 !i_output_enable_n[0] |-> !o_data_oe_n[0])
    else $error("flow read not driven");
  pipe_drive_a: assert property (!ft0 && rd0 && !i_lower_byte_enable_n[0] ##3 !i_output_enable_n[0] |-> !o_data_oe_n[0])
    else $error("pipe read not driven");
  write_float_a: assert property (!ft0 && s0 && !i_write_n[0] |-> ##3 o_data_oe_n[1:0] == 2'h3)
    else $error("write slot driven");
  clash_flag_a: assert property (both && ld2 && i_bank_select[5:0] == i_bank_select[11:6] |=> o_bank_collision)
    else $error("collision missed");
  clash_cause_a: assert property (o_bank_collision |-> $past(both))
    else $error("collision without cause");
  cover property (o_bank_collision);
  cover property (!ft0 && rd0 && i_upper_byte_enable_n[0]);
  cover property (ft0 && !s0);
endmodule // bsdp_chk
bind bsdp_top bsdp_chk #(.NPORT(NPORT), .BANK_W(BANK_W), .NLANE(NLANE)) chk_u (
  .i_ref_clk(i_ref_clk),
  .i_arst_n(i_arst_n),
  .i_pipeline_select(i_pipeline_select),
  .i_address_load_strobe_n(i_address_load_strobe_n),
  .i_chip_select_low_active_n(i_chip_select_low_active_n),
  .i_chip_select_high_active(i_chip_select_high_active),
  .i_upper_byte_enable_n(i_upper_byte_enable_n),
  .i_lower_byte_enable_n(i_lower_byte_enable_n),
  .i_write_n(i_write_n),
  .i_output_enable_n(i_output_enable_n),
  .i_bank_select(i_bank_select),
  .o_data_oe_n(o_data_oe_n),
  .o_bank_collision(o_bank_collision)
);
`default_nettype wire

// ==== verification/bsdp_ctl.sv ====
// random far-side controller driving the second port
`timescale 1ns/10ps
`default_nettype none
module bsdp_ctl
(
  input wire logic i_ref_clk,
  input wire logic i_en,
  input wire logic i_clash,
  input wire logic i_mode,
  output logic [9:0] o_ctl,
  output logic [5:0] o_bank,
  output logic [11:0] o_addr,
  output logic [17:0] o_data
);
  logic [31:0] r;
  initial {o_ctl, o_bank, o_addr, o_data} = {10'h1e1, 36'h0};
  // ****************************************
  // stimulus
  // ****************************************
  always @(negedge i_ref_clk)
  begin
    r = $urandom;
    // mode only follows i_mode, which moves in reset alone
    // both selects follow one enable bit in opposite senses, up long before data is awaited
    // separate random bits drive the upper and lower nine-bit lane enables
    o_ctl <= {i_mode, !i_clash & r[3] & r[4], r[7], r[5] | r[6],
      !i_en, i_en,
      r[8] & r[9], r[10] & r[11], r[12], r[13]};
    // banks 32..35 keep clear of the other port unless a clash is asked
    o_bank <= i_clash ? 6'h00 : {4'h8, r[16:15]};
    o_addr <= {9'h000, r[19:17]};
    // fresh pattern every cycle so stale data never looks valid
    o_data <= r[31:14];
  end
endmodule // bsdp_ctl
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench with a scoreboard model of both ports
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin n_errors++; $display("wrong value %s exp %h got %h", nm, e, s); end end
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode = 1'b0;
  logic p_en = 1'b0;
  logic clash = 1'b0;
  logic [8:0] af = 9'h1e1;
  logic [17:0] a_ad = 18'h00000;
  logic [17:0] a_dt = 18'h00000;
  logic [9:0] pc;
  logic [5:0] pb;
  logic [11:0] pa;
  logic [17:0] pd;
  logic [35:0] dq;
  logic [3:0] oe_n;
  logic coll;
  int n_errors = 0;
  int n_compared = 0;
  int mem[int];
  int ctr[2], last[2], drv[2][3], dat[2][3];
  always #12.5 clk = ~clk;
  bsdp_top dut_u (.i_ref_clk(clk), .i_arst_n(rst_n), .i_pipeline_select({pc[9], mode}),
    .i_address_load_strobe_n({pc[8], af[8]}), .i_counter_advance_enable_n({pc[7], af[7]}), .i_repeat_n({pc[6], af[6]}),
    .i_chip_select_low_active_n({pc[5], af[5]}), .i_chip_select_high_active({pc[4], af[4]}),
    .i_upper_byte_enable_n({pc[3], af[3]}), .i_lower_byte_enable_n({pc[2], af[2]}), .i_write_n({pc[1], af[1]}),
    .i_output_enable_n({pc[0], af[0]}), .i_bank_select({pb, a_ad[17:12]}), .i_address({pa, a_ad[11:0]}),
    .i_data({pd, a_dt}), .o_data(dq), .o_data_oe_n(oe_n), .o_bank_collision(coll));
  bsdp_ctl ctl_u (.i_ref_clk(clk), .i_en(p_en), .i_clash(clash), .i_mode(mode), .o_ctl(pc), .o_bank(pb),
    .o_addr(pa), .o_data(pd));
  // ****************************************
  // scoreboard
  // ****************************************
  always @(posedge clk)
  begin
    logic [9:0] c[2];
    logic sl[2];
    int ad[2], ext[2], wd[2], m, k, ec;
    c = '{{mode, af}, pc};
    ext = '{a_ad, {pb, pa}};
    wd = '{a_dt, pd};
    if (!rst_n)
    begin
      ctr = '{0, 0};
      last = '{0, 0};
      drv = '{default: 0};
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        ad[p] = !c[p][8] ? ext[p] : !c[p][6] ? last[p] : !c[p][7] ? (ctr[p] + 1) % 262144 : ctr[p];
        ctr[p] = ad[p];
        if (!c[p][8])
          last[p] = ext[p];
        sl[p] = !c[p][5] && c[p][4];
        for (k = 2; k > 0; k--)
        begin
          drv[p][k] = drv[p][k-1];
          dat[p][k] = dat[p][k-1];
        end
        drv[p][0] = (sl[p] && c[p][1]) ? 3 - c[p][3:2] : 0;
        dat[p][0] = mem.exists(ad[p]) ? mem[ad[p]] : -1;
      end
      ec = sl[0] && sl[1] && ad[0] / 4096 == ad[1] / 4096;
      if (ec)
      begin
        dat[0][0] = -1;
        dat[1][0] = -1;
        mem.delete(ad[0]);
        mem.delete(ad[1]);
      end
      for (int p = 0; p < 2; p++)
        if (sl[p] && !c[p][1] && !ec && (mem.exists(ad[p]) || c[p][3:2] == 2'h0))
        begin
          m = mem.exists(ad[p]) ? mem[ad[p]] : 0;
          mem[ad[p]] = ((c[p][3] ? m : wd[p]) & 32'h0003fe00) | ((c[p][2] ? m : wd[p]) & 32'h000001ff);
        end
      #2;
      for (int p = 0; p < 2; p++)
      begin
        k = c[p][9] ? 2 : 1;
        `CHK("lanes", ~drv[p][k][1:0] | {2{c[p][0]}}, oe_n[p*2+:2])
        if (drv[p][k] == 3 && dat[p][k] >= 0)
          `CHK("data", dat[p][k][17:0], dq[p*18+:18])
      end
      `CHK("collision", ec[0], coll)
    end
  end
  task automatic acc(input logic [8:0] f, input logic [17:0] ad, input logic [17:0] dt);
    @(negedge clk);
    af = f;
    a_ad = ad;
    a_dt = dt;
  endtask
  task automatic finish_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    int r;
    logic [17:0] rda[5] = '{18'h3ffff, 18'h00000, 18'h00ffe, 18'h01000, 18'h00fff};
    void'($urandom(32'h026405b9));
    for (int md = 0; md < 2; md++)
    begin
      rst_n = 1'b0;
      p_en <= 1'b0;
      mode <= md[0];
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      p_en <= 1'b1;
      acc(9'h0d1, 18'h00ffe, 18'h2a5a5);
      acc(9'h151, 18'h00000, 18'h15a5a);
      acc(9'h151, 18'h00000, 18'h3c3c3);
      acc(9'h0d1, 18'h3ffff, 18'h0f0f0);
      acc(9'h151, 18'h00000, 18'h12345);
      foreach (rda[i])
        acc(9'h0d2, rda[i], 18'h00000);
      acc(9'h1d2, 18'h00123, 18'h00000);
      acc(9'h152, 18'h00123, 18'h00000);
      acc(9'h192, 18'h00123, 18'h00000);
      acc(9'h0da, 18'h00fff, 18'h00000);
      acc(9'h0f2, 18'h00fff, 18'h00000);
      acc(9'h0d3, 18'h00fff, 18'h00000);
      acc(9'h0d1, 18'h00fff, 18'h2aaaa);
      acc(9'h0d2, 18'h00fff, 18'h00000);
      clash <= 1'b1;
      acc(9'h0d2, 18'h00ffe, 18'h00000);
      clash <= 1'b0;
      repeat (80)
      begin
        r = $urandom;
        acc({r[0] & r[1], r[2], r[3] | r[4], r[5] & r[6], 1'b1, r[7] & r[8], r[9] & r[10], r[11], r[12] & r[13]},
          {5'h00, r[14], 9'h000, r[17:15]}, r[31:14]);
      end
    end
    p_en <= 1'b0;
    repeat (6) acc(9'h1d2, 18'h00000, 18'h00000);
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
